// *** rtl/tmf_consts.vh ***
// Offsets, field positions, reset values and widths for the A-side match flag block
`ifndef TMF_CONSTS_VH
`define TMF_CONSTS_VH

// Bus widths
`define TMF_ADDR_W        8
`define TMF_DATA_W        32
`define TMF_CH_N          3

// Register byte offsets
`define TMF_OFF_FLAG      8'h00
`define TMF_OFF_ENABLE    8'h04
`define TMF_OFF_MODE      8'h08
`define TMF_OFF_CLEAR     8'h0C

// Field positions in the mode register
`define TMF_MODE_SYNC_BIT  0
`define TMF_MODE_PHASE_BIT 1

// Reset values
`define TMF_FLAG_RST      3'h0
`define TMF_ENABLE_RST    3'h0
`define TMF_MODE_RST      2'h0
`define TMF_RDATA_RST     32'h0000_0000

`endif

// *** rtl/tmf_match_flags_a.v ***
// A-side compare/capture flags, interrupt gating and channel 2 mode selects
`timescale 1ns/1ps
`default_nettype none
`include "tmf_consts.vh"

module tmf_match_flags_a
#(
  // Counter and register width
  parameter CNT_W = 16
)
(
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst_n,
  // Register port
  input  wire [`TMF_ADDR_W-1:0]  reg_addr,
  input  wire [`TMF_DATA_W-1:0]  reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output wire [`TMF_DATA_W-1:0]  reg_rdata,
  // Channel 0 datapath
  input  wire [CNT_W-1:0]        timer_counter_ch0,
  input  wire [CNT_W-1:0]        general_reg_a_ch0,
  input  wire                    capture_mode_ch0,
  input  wire                    capture_strobe_ch0,
  // Channel 1 datapath
  input  wire [CNT_W-1:0]        timer_counter_ch1,
  input  wire [CNT_W-1:0]        general_reg_a_ch1,
  input  wire                    capture_mode_ch1,
  input  wire                    capture_strobe_ch1,
  // Channel 2 datapath
  input  wire [CNT_W-1:0]        timer_counter_ch2,
  input  wire [CNT_W-1:0]        general_reg_a_ch2,
  input  wire                    capture_mode_ch2,
  input  wire                    capture_strobe_ch2,
  // Channel 2 synchronous operation
  input  wire                    sync_preset_req,
  input  wire                    sync_clear_req,
  output wire                    ch2_sync_mode,
  output wire                    ch2_sync_preset,
  output wire                    ch2_sync_clear,
  // Channel 2 phase counting
  input  wire                    phase_pin_a,
  input  wire                    phase_pin_b,
  output wire                    ch2_phase_mode,
  output wire                    ch2_count_up,
  output wire                    ch2_count_down,
  // Flags and interrupts
  output wire                    match_flag_a_ch0,
  output wire                    match_flag_a_ch1,
  output wire                    match_flag_a_ch2,
  output wire                    match_irq_a_ch0,
  output wire                    match_irq_a_ch1,
  output wire                    match_irq_a_ch2,
  output wire                    irq
);

  // Channel count is fixed by the one-port-per-channel interface
  localparam CH_N = `TMF_CH_N;

  // Address match against one register offset
  function addr_is;
    input [`TMF_ADDR_W-1:0] a;
    input [`TMF_ADDR_W-1:0] off;
    begin
      addr_is = (a == off);
    end
  endfunction

  // Channel buses packed for the generate loop
  wire [CNT_W*CH_N-1:0] cnt_all;
  wire [CNT_W*CH_N-1:0] gra_all;
  wire [CH_N-1:0]       cap_mode_all;
  wire [CH_N-1:0]       cap_strobe_all;

  assign cnt_all        = {timer_counter_ch2, timer_counter_ch1, timer_counter_ch0};
  assign gra_all        = {general_reg_a_ch2, general_reg_a_ch1, general_reg_a_ch0};
  assign cap_mode_all   = {capture_mode_ch2, capture_mode_ch1, capture_mode_ch0};
  assign cap_strobe_all = {capture_strobe_ch2, capture_strobe_ch1, capture_strobe_ch0};

  // Register state
  reg  [CH_N-1:0]        flag_q;
  reg  [CH_N-1:0]        flag_d;
  reg  [CH_N-1:0]        armed_q;
  reg  [CH_N-1:0]        armed_d;
  reg  [CH_N-1:0]        enable_q;
  reg  [CH_N-1:0]        enable_d;
  reg  [1:0]             mode_q;
  reg  [1:0]             mode_d;
  reg  [`TMF_DATA_W-1:0] rdata_q;
  reg  [`TMF_DATA_W-1:0] rdata_d;

  // Per-channel event detection
  reg  [CH_N-1:0]        cmp_hit_q;
  wire [CH_N-1:0]        cmp_hit;
  wire [CH_N-1:0]        set_evt;

  // Bus decode
  // Full-address decode; aliases of the four registers read zero
  wire sel_flag;
  wire sel_enable;
  wire sel_mode;
  wire sel_clear;

  assign sel_flag   = addr_is(reg_addr, `TMF_OFF_FLAG);
  assign sel_enable = addr_is(reg_addr, `TMF_OFF_ENABLE);
  assign sel_mode   = addr_is(reg_addr, `TMF_OFF_MODE);
  assign sel_clear  = addr_is(reg_addr, `TMF_OFF_CLEAR);

  // Compare and capture events, one set per channel
  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi = gi + 1)
    begin : g_ch
      // Capture mode masks the compare so one source owns the flag
      // compare equality
      assign cmp_hit[gi] = ~cap_mode_all[gi]
                         & (cnt_all[CNT_W*gi +: CNT_W] == gra_all[CNT_W*gi +: CNT_W]);
      assign set_evt[gi] = (cmp_hit[gi] & ~cmp_hit_q[gi])
                         | (cap_mode_all[gi] & cap_strobe_all[gi]);
    end
  endgenerate

  // Equality history so a held match sets the flag once
  // Without it a held match would set the flag again right after each clear
  always @(posedge clk)
  begin
    if (!rst_n)
      cmp_hit_q <= {CH_N{1'b0}};
    else
      cmp_hit_q <= cmp_hit;
  end

  // Clear requests, honoured only on bits armed by a read
  // Arming is per bit, so a read that showed 0 can never clear a later event
  wire [CH_N-1:0] wr_zero;
  wire [CH_N-1:0] wr_clear;
  wire [CH_N-1:0] clr_vec;

  assign wr_zero  = (reg_wr & sel_flag)  ? ~reg_wdata[CH_N-1:0] : {CH_N{1'b0}};
  assign wr_clear = (reg_wr & sel_clear) ?  reg_wdata[CH_N-1:0] : {CH_N{1'b0}};
  // clear needs a prior read of 1
  assign clr_vec  = armed_q & (wr_zero | wr_clear);

  // Flag and arming next state
  always @*
  begin
    // A clear that loses to a set still disarms; software must read again
    // set wins over clear
    flag_d  = (flag_q & ~clr_vec) | set_evt;
    armed_d = armed_q;
    // a read showing 1 arms the clear
    if (reg_rd && sel_flag)
      armed_d = armed_q | flag_q;
    // Any flag or clear write ends the sequence
    if (reg_wr && (sel_flag || sel_clear))
      armed_d = {CH_N{1'b0}};
  end

  // Enable and mode next state
  // Mode bits are written as a pair; other bits of the word are ignored
  always @*
  begin
    enable_d = enable_q;
    mode_d   = mode_q;
    if (reg_wr && sel_enable)
      enable_d = reg_wdata[CH_N-1:0];
    if (reg_wr && sel_mode)
    begin
      mode_d[`TMF_MODE_SYNC_BIT]  = reg_wdata[`TMF_MODE_SYNC_BIT];
      mode_d[`TMF_MODE_PHASE_BIT] = reg_wdata[`TMF_MODE_PHASE_BIT];
    end
  end

  // Read data mux; unmapped and clear register read zero
  // Read data stand for one cycle only; any other cycle returns zero
  always @*
  begin
    rdata_d = `TMF_RDATA_RST;
    if (reg_rd)
    begin
      if (sel_flag)
        rdata_d[CH_N-1:0] = flag_q;
      else if (sel_enable)
        rdata_d[CH_N-1:0] = enable_q;
      else if (sel_mode)
        rdata_d[1:0] = mode_q;
    end
  end

  // Register storage
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag_q   <= `TMF_FLAG_RST;
      armed_q  <= {CH_N{1'b0}};
      enable_q <= `TMF_ENABLE_RST;
      mode_q   <= `TMF_MODE_RST;
      rdata_q  <= `TMF_RDATA_RST;
    end
    else
    begin
      flag_q   <= flag_d;
      armed_q  <= armed_d;
      enable_q <= enable_d;
      mode_q   <= mode_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Channel 2 synchronous preset and clear, gated by the sync select
  // One cycle of latency keeps the group outputs glitch free
  reg sync_preset_q;
  reg sync_clear_q;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_preset_q <= 1'b0;
      sync_clear_q  <= 1'b0;
    end
    else
    begin
      sync_preset_q <= mode_q[`TMF_MODE_SYNC_BIT] & sync_preset_req;
      sync_clear_q  <= mode_q[`TMF_MODE_SYNC_BIT] & sync_clear_req;
    end
  end

  assign ch2_sync_mode   = mode_q[`TMF_MODE_SYNC_BIT];
  assign ch2_sync_preset = sync_preset_q;
  assign ch2_sync_clear  = sync_clear_q;

  // Phase pins pass two flip-flops, then one more stage for edges
  // The first stage may go metastable, so only the second and third stages feed the decode
  // Reset level 0 assumes idle-low pins; idle-high pins give one false up pulse and one false down pulse after reset
  reg pa_s1_q;
  reg pa_s2_q;
  reg pa_s3_q;
  reg pb_s1_q;
  reg pb_s2_q;
  reg pb_s3_q;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pa_s1_q <= 1'b0;
      pa_s2_q <= 1'b0;
      pa_s3_q <= 1'b0;
      pb_s1_q <= 1'b0;
      pb_s2_q <= 1'b0;
      pb_s3_q <= 1'b0;
    end
    else
    begin
      pa_s1_q <= phase_pin_a;
      pa_s2_q <= pa_s1_q;
      pa_s3_q <= pa_s2_q;
      pb_s1_q <= phase_pin_b;
      pb_s2_q <= pb_s1_q;
      pb_s3_q <= pb_s2_q;
    end
  end

  // Quadrature decode on synchronised levels only
  // Both pins changing in one cycle is illegal input and pulses both ways
  wire a_rise;
  wire a_fall;
  wire b_rise;
  wire b_fall;
  wire quad_up;
  wire quad_down;

  assign a_rise    =  pa_s2_q & ~pa_s3_q;
  assign a_fall    = ~pa_s2_q &  pa_s3_q;
  assign b_rise    =  pb_s2_q & ~pb_s3_q;
  assign b_fall    = ~pb_s2_q &  pb_s3_q;
  assign quad_up   = (a_rise & ~pb_s2_q) | (a_fall &  pb_s2_q)
                   | (b_rise &  pa_s2_q) | (b_fall & ~pa_s2_q);
  assign quad_down = (a_rise &  pb_s2_q) | (a_fall & ~pb_s2_q)
                   | (b_rise & ~pa_s2_q) | (b_fall &  pa_s2_q);

  // Count pulses only in phase counting mode
  reg count_up_q;
  reg count_down_q;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_up_q   <= 1'b0;
      count_down_q <= 1'b0;
    end
    else
    begin
      count_up_q   <= mode_q[`TMF_MODE_PHASE_BIT] & quad_up;
      count_down_q <= mode_q[`TMF_MODE_PHASE_BIT] & quad_down;
    end
  end

  assign ch2_phase_mode = mode_q[`TMF_MODE_PHASE_BIT];
  assign ch2_count_up   = count_up_q;
  assign ch2_count_down = count_down_q;

  // Flag outputs straight from storage
  assign match_flag_a_ch0 = flag_q[0];
  assign match_flag_a_ch1 = flag_q[1];
  assign match_flag_a_ch2 = flag_q[2];

  // Interrupt gating
  // Combinational from flops, so the level drops in the same cycle as the flag
  wire [CH_N-1:0] irq_vec;

  assign irq_vec         = flag_q & enable_q;
  assign match_irq_a_ch0 = irq_vec[0];
  assign match_irq_a_ch1 = irq_vec[1];
  assign match_irq_a_ch2 = irq_vec[2];
  assign irq             = |irq_vec;   // Level, high while any enabled flag set

endmodule // tmf_match_flags_a

`default_nettype wire

// *** verification/tmf_checker.sv ***
// Assertion checker for the A-side match flag block
`timescale 1ns/1ps
`default_nettype none
module tmf_checker
(
  // Clock, reset and register port
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Channel events and channel 2 modes
  input wire logic        capture_mode_ch0,
  input wire logic        capture_strobe_ch0,
  input wire logic        sync_preset_req,
  input wire logic        sync_clear_req,
  input wire logic        ch2_sync_mode,
  input wire logic        ch2_sync_preset,
  input wire logic        ch2_sync_clear,
  input wire logic        ch2_phase_mode,
  input wire logic        ch2_count_up,
  input wire logic        ch2_count_down,
  // Flags and interrupts
  input wire logic        match_flag_a_ch0,
  input wire logic        match_flag_a_ch2,
  input wire logic        match_irq_a_ch0,
  input wire logic        match_irq_a_ch1,
  input wire logic        match_irq_a_ch2,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_capture_sets:
    assert property (capture_mode_ch0 && capture_strobe_ch0 |=> match_flag_a_ch0)
    else $error("capture did not set flag");
  chk_one_keeps:
    assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[0] && match_flag_a_ch0
      |=> match_flag_a_ch0) else $error("write of one dropped flag");
  chk_clear_cause:
    assert property ($fell(match_flag_a_ch0) && $past(rst_n) |-> $past(reg_wr))
    else $error("flag fell without a write");
  chk_enable_gate:
    assert property (reg_wr && reg_addr == 8'h04 |=>
      match_irq_a_ch2 == (match_flag_a_ch2 && $past(reg_wdata[2])))
    else $error("channel 2 interrupt not gated by enable");
  chk_irq_join:
    assert property (irq == (match_irq_a_ch0 || match_irq_a_ch1 || match_irq_a_ch2)
      && (!match_irq_a_ch0 || match_flag_a_ch0)) else $error("interrupt output wrong");
  chk_sync_preset:
    assert property (sync_preset_req |=> ch2_sync_preset == $past(ch2_sync_mode))
    else $error("sync preset wrong");
  chk_sync_clear:
    assert property (ch2_sync_clear |-> $past(sync_clear_req) && $past(ch2_sync_mode))
    else $error("sync clear without cause");
  chk_phase_quiet:
    assert property ((!ch2_phase_mode)[*3] |-> !ch2_count_up && !ch2_count_down)
    else $error("count pulse outside phase mode");
  // Main scenarios reached
  cov_capture: cover property (capture_mode_ch0 && capture_strobe_ch0);
  cov_preset: cover property (ch2_sync_preset);
  cov_count: cover property (ch2_count_up);
endmodule // tmf_checker

bind tmf_match_flags_a tmf_checker u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .capture_mode_ch0, .capture_strobe_ch0, .sync_preset_req, .sync_clear_req, .ch2_sync_mode,
  .ch2_sync_preset, .ch2_sync_clear, .ch2_phase_mode, .ch2_count_up, .ch2_count_down,
  .match_flag_a_ch0, .match_flag_a_ch2, .match_irq_a_ch0, .match_irq_a_ch1,
  .match_irq_a_ch2, .irq);
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking testbench for the A-side match flag block
`timescale 1ns/1ps
`default_nettype none
`include "tmf_consts.vh"
module tb_top;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic        spre = 0, sclr = 0, pa = 0, pb = 0;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic [2:0]  cmode = 0, cstb = 0;
  logic [2:0][15:0] cnt = 48'hFFFF_FFFF_FFFF, gra = 0;
  logic [15:0] v;
  logic [2:0]  ef;
  wire  [31:0] rdata;
  wire  [2:0]  flag, mirq;
  wire         irq, smode, spset, sclrq, pmode, up, dn;
  logic [31:0] exp_q [$];
  int          failures = 0, n_checks = 0, n_up = 0, n_dn = 0, i, j;
  int          seed = 32'h6a78a614;

  // Device under test
  tmf_match_flags_a u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata(rdata), .timer_counter_ch0(cnt[0]), .general_reg_a_ch0(gra[0]),
    .capture_mode_ch0(cmode[0]), .capture_strobe_ch0(cstb[0]), .timer_counter_ch1(cnt[1]),
    .general_reg_a_ch1(gra[1]), .capture_mode_ch1(cmode[1]), .capture_strobe_ch1(cstb[1]),
    .timer_counter_ch2(cnt[2]), .general_reg_a_ch2(gra[2]), .capture_mode_ch2(cmode[2]),
    .capture_strobe_ch2(cstb[2]), .sync_preset_req(spre), .sync_clear_req(sclr),
    .ch2_sync_mode(smode), .ch2_sync_preset(spset), .ch2_sync_clear(sclrq),
    .phase_pin_a(pa), .phase_pin_b(pb), .ch2_phase_mode(pmode), .ch2_count_up(up),
    .ch2_count_down(dn), .match_flag_a_ch0(flag[0]), .match_flag_a_ch1(flag[1]),
    .match_flag_a_ch2(flag[2]), .match_irq_a_ch0(mirq[0]), .match_irq_a_ch1(mirq[1]),
    .match_irq_a_ch2(mirq[2]), .irq);

  // Clock
  always #2 clk = ~clk;

  // Compare one value and count the outcome
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_checks++;
    if (seen !== ex)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  // One register cycle; for a read, d is the expected answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
    @(posedge clk);
  endtask

  // Drive four quadrature steps, two bits per step
  task automatic quad(input logic [7:0] s);
    for (j = 0; j < 4; j++)
    begin
      {pa, pb} <= s[2*j +: 2];
      repeat (6) @(posedge clk);
    end
  endtask

  // Pulse both group requests for one cycle
  task automatic sync_pulse;
    spre <= 1;
    sclr <= 1;
    @(posedge clk);
    spre <= 0;
    sclr <= 0;
    @(posedge clk);
  endtask

  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Output monitor: read answers against the oldest note, count pulses
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    if (rd_d) chk("reg_rdata", rdata, exp_q.pop_front());
    if (up) n_up <= n_up + 1;
    if (dn) n_dn <= n_dn + 1;
  end

  // Watchdog
  initial
  begin
    #20000;
    failures++;
    end_sim;
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    bus(0, `TMF_OFF_FLAG, 0);
    bus(0, `TMF_OFF_ENABLE, 0);
    bus(0, `TMF_OFF_MODE, 0);
    bus(0, 8'h10, 0);
    $display("reset test done");
    ef = 0;
    for (i = 0; i < 3; i++)
    begin
      v = $random(seed);
      gra[i] <= v;
      cnt[i] <= v - 16'h0001;
      @(posedge clk);
      cnt[i] <= v;
      repeat (2) @(posedge clk);
      ef[i] = 1;
      chk("flag", flag, ef);
    end
    bus(1, `TMF_OFF_FLAG, 7);
    chk("flag", flag, 7);
    bus(1, `TMF_OFF_FLAG, 0);
    chk("flag", flag, 7);
    bus(0, `TMF_OFF_FLAG, 7);
    bus(1, `TMF_OFF_FLAG, 5);
    chk("flag", flag, 5);
    bus(0, `TMF_OFF_FLAG, 5);
    bus(1, `TMF_OFF_CLEAR, 1);
    chk("flag", flag, 4);
    bus(0, `TMF_OFF_CLEAR, 0);
    for (i = 0; i < 8; i++)
    begin
      bus(1, `TMF_OFF_ENABLE, i);
      chk("irq", {mirq, irq}, {flag & i[2:0], |(flag & i[2:0])});
    end
    bus(0, `TMF_OFF_ENABLE, 7);
    bus(0, `TMF_OFF_FLAG, 4);
    bus(1, `TMF_OFF_FLAG, 0);
    $display("compare and clear tests done");
    for (i = 0; i < 3; i++)
    begin
      cmode[i] <= 1;
      cnt[i] <= $random(seed);
      cstb[i] <= 1;
      @(posedge clk);
      cstb[i] <= 0;
      @(posedge clk);
      chk("flag", flag[i], 1);
    end
    bus(0, `TMF_OFF_FLAG, 7);
    fork
      bus(1, `TMF_OFF_FLAG, 0);
      begin
        cstb[0] <= 1;
        @(posedge clk);
        cstb[0] <= 0;
      end
    join
    chk("flag", flag, 1);
    $display("capture tests done");
    bus(1, `TMF_OFF_MODE, 3);
    bus(0, `TMF_OFF_MODE, 3);
    sync_pulse();
    chk("sync", {smode, spset, sclrq}, 7);
    quad(8'h1E);
    quad(8'h2D);
    chk("counts", {n_up[3:0], n_dn[3:0]}, 8'h44);
    bus(1, `TMF_OFF_MODE, 0);
    quad(8'h1E);
    chk("counts", {pmode, n_up[3:0], n_dn[3:0]}, 9'h044);
    sync_pulse();
    chk("sync", {smode, spset, sclrq}, 0);
    $display("mode tests done");
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
